// file: pkg/drf_regs.svh
// timing counts and field positions for the refresh and self-refresh control
// Operation
// - A12 on read/write picks burst: low chop four, high eight; never a column bit.
// - data setup/hold violation on a write corrupts only that write's location.
// - strobe or strobe-to-clock violation corrupts only that location; no hang.
// - refresh decoded when select, row and column strobe low, write enable high.
// - refresh rows come from an internal counter; address and bank inputs ignored.
// - finished refresh leaves every bank precharged and idle.
// - self-refresh entry is refresh pattern with clock enable low; banks idle.
// - loop enabled is switched off on entry, re-enabled with reset on exit; here only when dll_off_mode is low.
// - in self-refresh only clock enable and reset matter; internal clock gated.
// - one internal refresh within the pulse time, then built-in timer sustains.
`ifndef DRF_REGS_SVH
`define DRF_REGS_SVH
// ********************************************
// timing
// ********************************************
`define DRF_CLK_PS      4000
`define DRF_T_RFC_NS    160
`define DRF_T_CKE_NS    5
`define DRF_T_REFI_NS   7800
`define DRF_T_CCD_CK    4
`define DRF_RFC_CYC     ((`DRF_T_RFC_NS * 1000 + `DRF_CLK_PS - 1) / `DRF_CLK_PS)
`define DRF_CKE_CYC     ((`DRF_T_CKE_NS * 1000 + `DRF_CLK_PS - 1) / `DRF_CLK_PS)
`define DRF_REFI_CYC    ((`DRF_T_REFI_NS * 1000) / `DRF_CLK_PS)
// ********************************************
// fields
// ********************************************
`define DRF_BL_BIT      12
`endif

// file: pkg/drf_pkg.sv
// types for the refresh and self-refresh control
package drf_pkg;
  typedef struct packed {
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [2:0]  ba;
    logic [14:0] addr;
  } drf_cmd_type;

  typedef enum logic [2:0] {
    OP_NOP, OP_REF, OP_RD, OP_WR, OP_ACT, OP_PRE, OP_OTHER
  } drf_op_type;

  typedef enum {ST_NORM, ST_SREF} drf_state_type;

  function automatic drf_op_type drf_decode(input drf_cmd_type c);
    drf_op_type op;
    op = OP_OTHER;
    if (c.cs_n)
      op = OP_NOP;
    else
      case ({c.ras_n, c.cas_n, c.we_n})
        3'b111: op = OP_NOP;
        3'b001: op = OP_REF;
        3'b101: op = OP_RD;
        3'b100: op = OP_WR;
        3'b011: op = OP_ACT;
        3'b010: op = OP_PRE;
        default: op = OP_OTHER;
      endcase
    return op;
  endfunction
endpackage

// file: design/drf_ctrl.sv
// refresh, self-refresh, burst select and write-violation containment
`timescale 1ns/1ps
`include "drf_regs.svh"
module drf_ctrl
  import drf_pkg::*;
#(
  parameter int ROW_W  = 15,
  parameter int RFC_CYC = `DRF_RFC_CYC,
  parameter int CKE_CYC = `DRF_CKE_CYC,
  parameter int SR_CYC  = `DRF_REFI_CYC
) (
  input  wire logic              clock,           // 250 MHz core clock
  input  wire logic              rst,             // async reset, active high
  input  wire drf_cmd_type       cmd,             // command bus sample
  input  wire logic              dll_off_mode,    // mode bit A0
  input  wire logic              wr_viol,         // strobe timing fault in write
  output logic                   burst_valid_r,   // read/write accepted pulse
  output logic                   burst8_r,        // 1 = eight beats, 0 = chop
  output logic                   burst_wr_r,      // accepted command is write
  output logic [14:0]            col_addr_r,      // column, bit 12 zeroed
  output logic [ROW_W-1:0]       ref_row_r,       // internal refresh row
  output logic                   ref_strobe_r,    // one row refresh pulse
  output logic                   ref_busy,        // refresh cycle running
  output logic [7:0]             bank_open_r,     // open bank map
  output logic                   in_sref,         // self-refresh state
  output logic                   iclk_en_r,       // internal clock gate
  output logic                   dll_en_r,        // loop enabled
  output logic                   dll_rst_r,       // loop reset pulse
  output logic                   corrupt_valid_r, // location may be corrupt
  output logic [17:0]            corrupt_loc_r    // bank and column
);
  // ********************************************
  // decode
  // ********************************************
  drf_state_type   state_r;
  drf_op_type      op;
  logic            cke_prev_r;
  logic            act_cmd;
  logic            sre;
  logic            ref_go;
  logic            sr_tick;
  logic            sr_exit;
  logic [15:0]     rfc_cnt_r;
  logic [15:0]     sr_cnt_r;
  logic [15:0]     stay_cnt_r;
  logic [17:0]     wr_loc_r;

  assign op      = drf_decode(cmd);
  assign in_sref = (state_r == ST_SREF);
  assign act_cmd = (state_r == ST_NORM) && cke_prev_r && cmd.cke;
  assign sre     = (state_r == ST_NORM) && cke_prev_r && !cmd.cke && (op == OP_REF);
  assign sr_tick = in_sref && (sr_cnt_r == 16'h0000);
  assign sr_exit = in_sref && cmd.cke && (stay_cnt_r >= 16'(CKE_CYC));
  assign ref_go  = (act_cmd && op == OP_REF) || sre || sr_tick;
  assign ref_busy = (rfc_cnt_r != 16'h0000);

  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      cke_prev_r <= 1'b0;
    else
      cke_prev_r <= cmd.cke;
  end

  // ********************************************
  // state
  // ********************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= ST_NORM;
    end else begin
      case (state_r)
        ST_NORM: if (sre) state_r <= ST_SREF;
        ST_SREF: if (sr_exit) state_r <= ST_NORM;
        default: state_r <= ST_NORM;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      iclk_en_r <= 1'b1;
    else if (sre)
      iclk_en_r <= 1'b0;
    else if (sr_exit)
      iclk_en_r <= 1'b1;
  end

  // loop off on entry, on with reset at exit only when dll_off_mode is low
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dll_en_r  <= 1'b1;
      dll_rst_r <= 1'b0;
    end else begin
      dll_rst_r <= sr_exit && !dll_off_mode;
      if (sre)
        dll_en_r <= 1'b0;
      else if (sr_exit)
        dll_en_r <= !dll_off_mode;
    end
  end

  // ********************************************
  // refresh
  // ********************************************
  // internal row counter
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ref_row_r    <= '0;
      ref_strobe_r <= 1'b0;
    end else begin
      ref_strobe_r <= ref_go;
      if (ref_go)
        ref_row_r <= ref_row_r + 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      rfc_cnt_r <= 16'h0000;
    else if (ref_go)
      rfc_cnt_r <= 16'(RFC_CYC);
    else if (ref_busy)
      rfc_cnt_r <= rfc_cnt_r - 16'h0001;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sr_cnt_r   <= 16'h0000;
      stay_cnt_r <= 16'h0000;
    end else if (sre) begin
      sr_cnt_r   <= 16'(SR_CYC - 1);
      stay_cnt_r <= 16'h0000;
    end else if (in_sref) begin
      sr_cnt_r <= sr_tick ? 16'(SR_CYC - 1) : sr_cnt_r - 16'h0001;
      if (stay_cnt_r != 16'hFFFF)
        stay_cnt_r <= stay_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      bank_open_r <= 8'h00;
    else if (ref_go)
      bank_open_r <= 8'h00;
    else if (act_cmd && op == OP_ACT)
      bank_open_r[cmd.ba] <= 1'b1;
    else if (act_cmd && op == OP_PRE) begin
      if (cmd.addr[10])
        bank_open_r <= 8'h00;
      else
        bank_open_r[cmd.ba] <= 1'b0;
    end
  end

  // ********************************************
  // burst select
  // ********************************************
  // bit 12 picks length
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      burst_valid_r <= 1'b0;
      burst8_r      <= 1'b1;
      burst_wr_r    <= 1'b0;
      col_addr_r    <= 15'h0000;
      wr_loc_r      <= 18'h0_0000;
    end else begin
      burst_valid_r <= act_cmd && (op == OP_RD || op == OP_WR);
      if (act_cmd && (op == OP_RD || op == OP_WR)) begin
        burst8_r   <= cmd.addr[`DRF_BL_BIT];
        burst_wr_r <= (op == OP_WR);
        col_addr_r <= cmd.addr & ~(15'h0001 << `DRF_BL_BIT);
        if (op == OP_WR)
          wr_loc_r <= {cmd.ba, cmd.addr & ~(15'h0001 << `DRF_BL_BIT)};
      end
    end
  end

  // ********************************************
  // write violation
  // ********************************************
  // flag only the written location
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      corrupt_valid_r <= 1'b0;
      corrupt_loc_r   <= 18'h0_0000;
    end else begin
      corrupt_valid_r <= wr_viol;
      if (wr_viol)
        corrupt_loc_r <= wr_loc_r;
    end
  end

  // ********************************************
  // assertions
  // ********************************************
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  a_burst_len_sel: assert property (
    (act_cmd && (op == OP_RD || op == OP_WR)) |=> burst_valid_r && burst8_r == $past(cmd.addr[12])
      && col_addr_r[12] == 1'b0)
    else $error("burst length select wrong");
  a_viol_loc_only: assert property (
    wr_viol |=> corrupt_valid_r && corrupt_loc_r == $past(wr_loc_r))
    else $error("violation flagged wrong location");
  a_viol_no_hang: assert property (
    (wr_viol && state_r == ST_NORM && !sre) |=> state_r == ST_NORM)
    else $error("violation disturbed state");
  a_ref_decode: assert property (
    (act_cmd && op == OP_REF) |=> ref_strobe_r ##1 ref_busy)
    else $error("refresh not decoded");
  a_ref_row_step: assert property (
    ref_strobe_r |-> ref_row_r == ROW_W'($past(ref_row_r) + 1'b1))
    else $error("refresh row not from counter");
  a_ref_banks_idle: assert property (
    ref_strobe_r |-> bank_open_r == 8'h00)
    else $error("banks open after refresh");
  a_sre_enter: assert property (
    sre |=> in_sref && !iclk_en_r)
    else $error("self-refresh entry missed");
  a_sre_dll_off: assert property (
    sre |=> !dll_en_r)
    else $error("loop not off in self-refresh");
  a_srx_dll_rst: assert property (
    (sr_exit && !dll_off_mode) |=> dll_rst_r && dll_en_r && !in_sref)
    else $error("loop not reset at exit");
  a_sref_ignore: assert property (
    (in_sref && $past(in_sref)) |-> !burst_valid_r && bank_open_r == $past(bank_open_r))
    else $error("command taken in self-refresh");
  a_sref_first_ref: assert property (
    sre |=> ref_strobe_r)
    else $error("no refresh at entry");

  c_refresh: cover property (act_cmd && op == OP_REF);
  c_sref_tick: cover property (sr_tick);
  c_sref_exit: cover property (sr_exit);
  c_violation: cover property (wr_viol && burst_wr_r);
endmodule

// file: tb/drf_host.sv
// controller-side model driving the command bus
`timescale 1ns/1ps
module drf_host
  import drf_pkg::*;
#(
  parameter int RFC_CYC = 8,
  parameter int XS_CYC  = 8  // deselects held after self-refresh exit
) (
  input  wire logic  clock, // core clock
  output drf_cmd_type cmd   // command bus to device
);
  // ********************************
  // command issue
  // ********************************
  initial cmd = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 15'h0000};

  task automatic put(input logic ke, input logic [3:0] c, input logic [2:0] b,
                     input logic [14:0] a);
    @(negedge clock);
    cmd <= '{ke, c[3], c[2], c[1], c[0], b, a};
    @(negedge clock);
    cmd <= '{ke, 1'b1, 1'b1, 1'b1, 1'b1, ~b, ~a};
  endtask

  task automatic refr();
    repeat (XS_CYC) @(negedge clock);
    put(1'b1, 4'b0001, 3'h0, 15'h0000);
    repeat (RFC_CYC) @(negedge clock);
  endtask

  // clock kept, exit with deselect
  task automatic srx();
    @(negedge clock);
    cmd <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, ~cmd.ba, ~cmd.addr};
  endtask
endmodule

// file: tb/tb_top.sv
// self-checking bench for the refresh and self-refresh control
`timescale 1ns/1ps
module tb_top;
  import drf_pkg::*;
  localparam int RFC = 8;
  localparam int SR  = 20;
  logic        clock        = 1'b0;
  logic        rst          = 1'b1;
  logic        dll_off_mode = 1'b0;
  logic        wr_viol      = 1'b0;
  drf_cmd_type cmd;
  logic        burst_valid_r, burst8_r, burst_wr_r, ref_strobe_r, ref_busy;
  logic        in_sref, iclk_en_r, dll_en_r, dll_rst_r, corrupt_valid_r;
  logic [14:0] col_addr_r, ref_row_r;
  logic [7:0]  bank_open_r;
  logic [17:0] corrupt_loc_r;
  int          bad_count    = 0;
  int          total_checks = 0;
  int          cycles       = 0;

  always #2 clock = ~clock;

  drf_host #(.RFC_CYC(RFC)) i_drf_host (.clock(clock), .cmd(cmd));
  drf_ctrl #(.ROW_W(15), .RFC_CYC(RFC), .CKE_CYC(2), .SR_CYC(SR)) i_drf_ctrl (
    .clock(clock), .rst(rst), .cmd(cmd), .dll_off_mode(dll_off_mode),
    .wr_viol(wr_viol), .burst_valid_r(burst_valid_r), .burst8_r(burst8_r),
    .burst_wr_r(burst_wr_r), .col_addr_r(col_addr_r), .ref_row_r(ref_row_r),
    .ref_strobe_r(ref_strobe_r), .ref_busy(ref_busy), .bank_open_r(bank_open_r),
    .in_sref(in_sref), .iclk_en_r(iclk_en_r), .dll_en_r(dll_en_r),
    .dll_rst_r(dll_rst_r), .corrupt_valid_r(corrupt_valid_r),
    .corrupt_loc_r(corrupt_loc_r));

  // ********************************
  // helpers
  // ********************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic rw(input logic w, input logic a12, input logic [2:0] b,
                    input logic [14:0] c);
    i_drf_host.put(1'b1, {3'b010, ~w}, b, {c[14:13], a12, c[11:0]});
    chk(burst_valid_r, 1);
    chk(burst8_r, a12);
    chk(burst_wr_r, w);
    chk(col_addr_r, {c[14:13], 1'b0, c[11:0]});
  endtask

  // ********************************
  // scenarios
  // ********************************
  task automatic t_burst();
    i_drf_host.put(1'b1, 4'b0011, 3'h2, 15'h0010);
    chk(bank_open_r, 8'h04);
    for (int i = 0; i < 4; i++) begin
      rw(i[0], i[1], 3'h2, 15'h50a8 ^ 15'(i));
      repeat (2) @(posedge clock);
    end
  endtask

  task automatic t_viol();
    rw(1'b1, 1'b1, 3'h5, 15'h0123);
    @(negedge clock);
    wr_viol = 1'b1;
    @(negedge clock);
    wr_viol = 1'b0;
    chk(corrupt_valid_r, 1);
    chk(corrupt_loc_r, {3'h5, 15'h0123});
    @(negedge clock);
    chk(corrupt_valid_r, 0);
    rw(1'b0, 1'b0, 3'h5, 15'h0040);
  endtask

  task automatic t_ref();
    logic [14:0] row0;
    int busy;
    busy = 0;
    i_drf_host.put(1'b1, 4'b0010, 3'h2, 15'h0400);
    chk(bank_open_r, 0);
    repeat (4) @(posedge clock);
    #1;
    row0 = ref_row_r;
    i_drf_host.put(1'b1, 4'b0001, 3'h7, 15'h7fff);
    chk(ref_strobe_r, 1);
    chk(ref_row_r, row0 + 15'h0001);
    chk(bank_open_r, 0);
    repeat (RFC + 3) begin
      busy += int'(ref_busy);
      @(posedge clock);
      #1;
    end
    chk(busy, RFC);
  endtask

  task automatic t_sref(input logic m);
    int n;
    n = 0;
    @(negedge clock);
    dll_off_mode = m;
    i_drf_host.put(1'b0, 4'b0001, 3'h3, 15'h1234);
    chk(in_sref, 1);
    chk(iclk_en_r, 0);
    chk(dll_en_r, 0);
    chk(ref_strobe_r, 1);
    i_drf_host.put(1'b0, 4'b0100, 3'h1, 15'h0008);
    chk(burst_valid_r, 0);
    repeat (2 * SR + 1) begin
      @(posedge clock);
      #1;
      n += int'(ref_strobe_r);
    end
    chk(n >= 2, 1);
    i_drf_host.srx();
    @(negedge clock);
    chk(in_sref, 0);
    chk(iclk_en_r, 1);
    chk(dll_en_r, !m);
    chk(dll_rst_r, !m);
    i_drf_host.refr();
  endtask

  initial begin
    repeat (2) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    t_burst();
    t_viol();
    t_ref();
    t_sref(1'b0);
    t_sref(1'b1);
    tally_and_finish();
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      tally_and_finish();
    end
  end
endmodule
